// >>> hw/spwm_chan.sv
// standard pwm channel with apb register slave
`timescale 1ns/1ps
module spwm_chan
  import spwm_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SLEEP,
  output logic             WAVE_OUT,
  output logic             WAVE_OE,
  output logic             PIN_CLAIM
);
  logic [7:0]            ctrl_q;
  logic [7:0]            cmp_lo_q;
  logic [7:0]            cmp_hi_q;
  logic [1:0]            dlat_q;
  logic [1:0]            tsel_q;
  logic                  dir_q;
  logic [SPWM_CFG_W-1:0] cfg_q [SPWM_NTMR];
  logic [SPWM_NTMR-1:0]  flag_q;
  logic [SPWM_NTMR-1:0]  roll_w;
  logic [7:0]            cnt_w [SPWM_NTMR];
  logic [1:0]            sub_w [SPWM_NTMR];
  logic                  wave_q;
  logic                  wave_d;
  logic                  claim_q;
  logic                  oe_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;

  // apb decode
  logic        setup_w;
  logic        wr_w;
  logic        hit_ctrl;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_tsel;
  logic        hit_cfg;
  logic        hit_stat;
  logic        hit_pin;
  logic        mapped_w;
  logic [1:0]  cfg_idx_w;
  logic [31:0] rd_w;

  assign setup_w   = PSEL & ~PENABLE;
  assign wr_w      = PSEL & PENABLE & pready_q & PWRITE;
  assign hit_ctrl  = PADDR == SPWM_OFS_CTRL;
  assign hit_lo    = PADDR == SPWM_OFS_CMPLO;
  assign hit_hi    = PADDR == SPWM_OFS_CMPHI;
  assign hit_tsel  = PADDR == SPWM_OFS_TSEL;
  assign hit_stat  = PADDR == SPWM_OFS_STAT;
  assign hit_pin   = PADDR == SPWM_OFS_PIN;
  assign hit_cfg   = (PADDR >= SPWM_OFS_CFG0) && (PADDR <= SPWM_OFS_CFG2) &&
                     (PADDR[1:0] == 2'h0);
  assign cfg_idx_w = 2'(PADDR[7:2] - SPWM_OFS_CFG0[7:2]);
  assign mapped_w  = hit_ctrl | hit_lo | hit_hi | hit_tsel | hit_cfg | hit_stat | hit_pin;

  // pwm datapath
  logic       pwm_w;
  logic [1:0] sel_w;
  logic       roll_sel_w;
  logic [9:0] tb_w;
  logic [9:0] duty_pend_w;
  logic [9:0] duty_act_w;
  logic       match_w;
  logic       wr_hi_w;
  logic       start_q;
  logic       start_d;

  assign pwm_w       = ctrl_q[SPWM_MODE_LSB+1:SPWM_MODE_LSB] == SPWM_MODE_PWM;
  assign sel_w       = (tsel_q == SPWM_TSEL_RSVD) ? 2'h0 : tsel_q;
  assign roll_sel_w  = roll_w[sel_w];
  assign tb_w        = {cnt_w[sel_w], sub_w[sel_w]};
  assign duty_pend_w = {cmp_lo_q, ctrl_q[SPWM_DUTY_LSB+1:SPWM_DUTY_LSB]};
  assign duty_act_w  = {cmp_hi_q, dlat_q};
  // a duty beyond the period never matches, so the pin stays high
  assign match_w     = pwm_w & (tb_w == duty_act_w);
  assign wr_hi_w     = wr_w & hit_hi;
  // period start applied a clock after rollover, held through sleep
  assign start_d     = SLEEP ? start_q : (pwm_w & roll_sel_w);

  assign rd_w = ({32{hit_ctrl}} & {24'h000000, ctrl_q}) |
                ({32{hit_lo}}   & {24'h000000, cmp_lo_q}) |
                ({32{hit_hi}}   & {24'h000000, cmp_hi_q}) |
                ({32{hit_tsel}} & {30'h00000000, tsel_q}) |
                ({32{hit_cfg}}  & {17'h00000, cfg_q[cfg_idx_w]}) |
                ({32{hit_stat}} & {20'h00000, flag_q, wave_q, cnt_w[sel_w]}) |
                ({32{hit_pin}}  & {31'h00000000, dir_q});

  always_comb begin
    wave_d = wave_q;
    if (ctrl_q == SPWM_CTRL_RST) begin
      wave_d = 1'b0;
    end else if (pwm_w && !SLEEP) begin
      if (start_q) begin
        wave_d = duty_act_w != 10'h000;
      end else if (match_w) begin
        wave_d = 1'b0;
      end
    end
  end

  // three period timers, postscaler bits stored but never used
  genvar k;
  generate
    for (k = 0; k < SPWM_NTMR; k++) begin : g_tmr
      logic wr_cfg_w;
      logic clr_flag_w;
      assign wr_cfg_w   = wr_w & hit_cfg & (cfg_idx_w == 2'(k));
      assign clr_flag_w = wr_w & hit_stat & PWDATA[SPWM_ST_FLAG+k];

      spwm_tmr u_tmr (
        .clk    (CORE_CLK),
        .rst_n  (RESETN),
        .run    (cfg_q[k][SPWM_CFG_RUN]),
        .hold   (SLEEP),
        .ps     (cfg_q[k][SPWM_CFG_PS+1:SPWM_CFG_PS]),
        .period (cfg_q[k][7:0]),
        .cnt    (cnt_w[k]),
        .sub    (sub_w[k]),
        .roll   (roll_w[k])
      );

      always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
          cfg_q[k]  <= SPWM_CFG_RST;
          flag_q[k] <= 1'b0;
        end else begin
          if (wr_cfg_w) begin
            cfg_q[k] <= PWDATA[SPWM_CFG_W-1:0];
          end
          flag_q[k] <= roll_w[k] | (flag_q[k] & ~clr_flag_w);
        end
      end
    end
  endgenerate

  // software registers
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      ctrl_q   <= SPWM_CTRL_RST;
      cmp_lo_q <= SPWM_BYTE_RST;
      tsel_q   <= SPWM_TSEL_RST;
      dir_q    <= SPWM_DIR_RST;
    end else if (wr_w) begin
      if (hit_ctrl) begin
        ctrl_q <= PWDATA[7:0];
      end
      if (hit_lo) begin
        cmp_lo_q <= PWDATA[7:0];
      end
      if (hit_tsel) begin
        tsel_q <= PWDATA[1:0];
      end
      if (hit_pin) begin
        dir_q <= PWDATA[0];
      end
    end
  end

  // duty shadow, loaded at period end in pwm mode, written by software otherwise
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      cmp_hi_q <= SPWM_BYTE_RST;
      dlat_q   <= 2'h0;
    end else if (pwm_w && roll_sel_w) begin
      cmp_hi_q <= cmp_lo_q;
      dlat_q   <= ctrl_q[SPWM_DUTY_LSB+1:SPWM_DUTY_LSB];
    end else if (wr_hi_w && !pwm_w) begin
      cmp_hi_q <= PWDATA[7:0];
    end
  end

  // pin and bus outputs
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      wave_q    <= 1'b0;
      start_q   <= 1'b0;
      claim_q   <= 1'b0;
      oe_q      <= 1'b0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      wave_q    <= wave_d;
      start_q   <= start_d;
      claim_q   <= ctrl_q != SPWM_CTRL_RST;
      oe_q      <= (ctrl_q != SPWM_CTRL_RST) & ~dir_q;
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~mapped_w;
      if (setup_w) begin
        prdata_q <= rd_w;
      end
    end
  end

  assign WAVE_OUT  = wave_q;
  assign WAVE_OE   = oe_q;
  assign PIN_CLAIM = claim_q;
  assign PRDATA    = prdata_q;
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  chk_roll_sets_pin: assert property (
    (pwm_w && roll_sel_w && duty_pend_w != 10'h000) ##1 (pwm_w && !SLEEP) |=> WAVE_OUT)
    else $error("pin not set at period start");
  chk_zero_duty_low: assert property (
    (pwm_w && roll_sel_w && duty_pend_w == 10'h000) ##1 (pwm_w && !SLEEP) |=> !WAVE_OUT)
    else $error("pin set with zero duty");
  chk_shadow_load: assert property (
    pwm_w && roll_sel_w |=> cmp_hi_q == $past(cmp_lo_q) &&
                            dlat_q == $past(duty_pend_w[1:0]))
    else $error("duty not latched at period start");
  chk_high_readonly: assert property (
    pwm_w && wr_hi_w && !roll_sel_w |=> $stable(cmp_hi_q))
    else $error("high byte written in pwm mode");
  chk_match_clear: assert property (
    pwm_w && match_w && !roll_sel_w && !SLEEP |=> !WAVE_OUT)
    else $error("pin not cleared on duty match");
  chk_sleep_hold: assert property (
    SLEEP && !wr_w && $stable(SLEEP) |=> $stable(WAVE_OUT) ##1 $stable(WAVE_OUT) or !SLEEP)
    else $error("pin moved during sleep");
  chk_release_pin: assert property (
    ctrl_q == SPWM_CTRL_RST && !wr_w |=> ##1 !PIN_CLAIM && !WAVE_OE && !WAVE_OUT)
    else $error("pin not released");
  chk_dir_gates_oe: assert property (
    dir_q && !wr_w |=> ##1 !WAVE_OE)
    else $error("driver enabled with input direction");
  chk_flag_on_roll: assert property (
    roll_w[0] |=> flag_q[0])
    else $error("match flag not set");
  chk_sleep_freeze: assert property (
    SLEEP |-> roll_w == '0 ##1 $stable(cnt_w[0]))
    else $error("timer moved during sleep");

  cov_period_start: cover property (pwm_w && roll_sel_w && duty_pend_w != 10'h000);
  cov_duty_match:   cover property (pwm_w && match_w && WAVE_OUT);
  cov_sleep_high:   cover property (SLEEP && WAVE_OUT && pwm_w);
endmodule

// >>> hw/spwm_pkg.sv
// constants for the standard pwm channel
// Overview of operation
// - period match clears count, sets pin, loads duty
// - zero duty keeps pin low at period start
// - period is (period+1) x 4 x prescale clocks
// - duty is low byte plus two low bits
// - new duty applies only after period match
// - high byte read-only in pwm mode
// - active duty double-buffered in high byte, latch
// - timebase is count plus two sub-count bits
// - timebase equal to active duty clears pin
// - duty beyond period leaves pin high
// - timer select field picks one of three timers
// - postscaler has no effect on period
// - ten bits resolution at period 255
// - prescale selectable among 1, 4, 16
// - sleep freezes count and channel state
// - sleep holds pin at its level
// - control cleared to zero releases pin
// - driver enabled only when direction is output
// - timer rollover sets timer match flag
// - reset restores registers, pin to input
package spwm_pkg;
  localparam int          SPWM_NTMR       = 3;
  localparam int          SPWM_CFG_W      = 15;
  localparam logic [7:0]  SPWM_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  SPWM_OFS_CMPLO  = 8'h04;
  localparam logic [7:0]  SPWM_OFS_CMPHI  = 8'h08;
  localparam logic [7:0]  SPWM_OFS_TSEL   = 8'h0C;
  localparam logic [7:0]  SPWM_OFS_CFG0   = 8'h10;
  localparam logic [7:0]  SPWM_OFS_CFG2   = 8'h18;
  localparam logic [7:0]  SPWM_OFS_STAT   = 8'h1C;
  localparam logic [7:0]  SPWM_OFS_PIN    = 8'h20;
  localparam int          SPWM_DUTY_LSB   = 4;
  localparam int          SPWM_MODE_LSB   = 2;
  localparam logic [1:0]  SPWM_MODE_PWM   = 2'h3;
  localparam logic [1:0]  SPWM_TSEL_RSVD  = 2'h3;
  localparam int          SPWM_CFG_PS     = 8;
  localparam int          SPWM_CFG_RUN    = 10;
  localparam int          SPWM_ST_WAVE    = 8;
  localparam int          SPWM_ST_FLAG    = 9;
  localparam logic [7:0]  SPWM_CTRL_RST   = 8'h00;
  localparam logic [7:0]  SPWM_BYTE_RST   = 8'h00;
  localparam logic [1:0]  SPWM_TSEL_RST   = 2'h0;
  localparam logic        SPWM_DIR_RST    = 1'b1;
  localparam logic [14:0] SPWM_CFG_RST    = 15'h0000;
  localparam logic [1:0]  SPWM_PS_1       = 2'h0;
  localparam logic [1:0]  SPWM_PS_4       = 2'h1;
  localparam logic [5:0]  SPWM_PRE_LAST1  = 6'h03;
  localparam logic [5:0]  SPWM_PRE_LAST4  = 6'h0F;
  localparam logic [5:0]  SPWM_PRE_LAST16 = 6'h3F;
endpackage

// >>> hw/spwm_tmr.sv
// one 8-bit period timer with prescaler and sub-count bits
`timescale 1ns/1ps
module spwm_tmr
  import spwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       hold,
  input  wire logic [1:0] ps,
  input  wire logic [7:0] period,
  output logic      [7:0] cnt,
  output logic      [1:0] sub,
  output logic            roll
);
  logic [5:0] pre_q;
  logic [5:0] pre_d;
  logic [5:0] last_w;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       inc_w;

  // four clocks per count, times the prescale
  assign last_w = (ps == SPWM_PS_1) ? SPWM_PRE_LAST1 :
                  (ps == SPWM_PS_4) ? SPWM_PRE_LAST4 : SPWM_PRE_LAST16;
  assign inc_w  = run & ~hold & (pre_q == last_w);
  assign roll   = inc_w & (cnt_q == period);
  assign pre_d  = ~run ? 6'h00 : (hold ? pre_q : (inc_w ? 6'h00 : pre_q + 6'h01));
  assign cnt_d  = roll ? 8'h00 : (inc_w ? cnt_q + 8'h01 : cnt_q);
  // clock phase at 1:1, prescaler bits otherwise
  assign sub    = (ps == SPWM_PS_1) ? pre_q[1:0] :
                  (ps == SPWM_PS_4) ? pre_q[3:2] : pre_q[5:4];
  assign cnt    = cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= 6'h00;
      cnt_q <= 8'h00;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> test/spwm_chan_test.sv
// self-checking bench for the standard pwm channel
`timescale 1ns/1ps
module spwm_chan_test;
  import spwm_pkg::*;
  localparam logic [31:0] MPWM = 32'(SPWM_MODE_PWM) << SPWM_MODE_LSB;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel  = 1'b0;
  logic        pen   = 1'b0;
  logic        pwr   = 1'b0;
  logic        slp   = 1'b0;
  logic [7:0]  pa    = 8'h00;
  logic [31:0] pwd   = 32'h0;
  logic [31:0] prd, rv, cfg;
  logic        pready, perr, wout, woe, claim, ev;
  logic [15:0] hi_len, per_len;
  logic [7:0]  ca;
  int          err_count = 0;
  int          n_tests = 0;
  int          h, p, d, k, n;
  always #20 clk = ~clk;
  spwm_chan spwm_chan_i (.CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready),
    .PSLVERR(perr), .SLEEP(slp), .WAVE_OUT(wout), .WAVE_OE(woe), .PIN_CLAIM(claim));
  spwm_load spwm_load_i (.clk(clk), .pin_out(wout), .pin_oe(woe), .hi_len(hi_len),
    .per_len(per_len));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int m;
    m = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++m < 50);
    if (m >= 50) err_count++;
    rv = prd;
    ev = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    cmp("pslverr", 32'h0, {31'h0, ev});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rv);
  endtask
  task automatic hiwin(input int c);
    h = 0;
    repeat (c) begin
      @(negedge clk);
      h += (wout === 1'b1 && woe === 1'b1) ? 1 : 0;
    end
  endtask
  function automatic int psf(input int t);
    return t == 0 ? 1 : (t == 1 ? 4 : 16);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 90000);
    err_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(26));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cmp("claim", 32'h0, {31'h0, claim});
    rdc("pin", SPWM_OFS_PIN, 32'h1);
    rdc("cfg2", SPWM_OFS_CFG2, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, ev});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      k = i % 3;
      p = (i == 3) ? 255 : 1 + $urandom % 6;
      d = 1 + $urandom % (4 * p + 3);
      ca = SPWM_OFS_CFG0 + 8'(4 * k);
      cfg = 32'(p) | 32'(k) << SPWM_CFG_PS | 32'($urandom % 16) << 11;
      wr(SPWM_OFS_PIN, 32'h1);
      wr(ca, cfg);
      wr(SPWM_OFS_CTRL, MPWM | 32'(d % 4) << SPWM_DUTY_LSB);
      wr(SPWM_OFS_CMPLO, 32'(d / 4));
      wr(SPWM_OFS_TSEL, 32'(k));
      wr(SPWM_OFS_STAT, 32'hE00);
      wr(ca, cfg | 32'h1 << SPWM_CFG_RUN);
      cmp("oe off", 32'h0, {31'h0, woe});
      n = 0;
      do apb(1'b0, SPWM_OFS_STAT, 32'h0); while (rv[SPWM_ST_FLAG + k] !== 1'b1 && ++n < 900);
      cmp("flag", 32'h1, 32'(rv[SPWM_ST_FLAG + k]));
      wr(SPWM_OFS_PIN, 32'h0);
      repeat (12 * (p + 1) * psf(k) + 8) @(posedge clk);
      cmp("period", 32'(4 * (p + 1) * psf(k)), 32'(per_len));
      cmp("high", 32'(d * psf(k)), 32'(hi_len));
      cmp("oe on", 32'h1, {31'h0, woe});
      wr(SPWM_OFS_CMPHI, 32'h5A);
      rdc("cmphi", SPWM_OFS_CMPHI, 32'(d / 4));
      wr(ca, 32'h0);
      $display("test timer %0d done", k);
    end
    wr(SPWM_OFS_CMPLO, 32'h0);
    wr(SPWM_OFS_CTRL, MPWM);
    wr(SPWM_OFS_STAT, 32'hE00);
    wr(SPWM_OFS_CFG0, 32'h3 | 32'h1 << SPWM_CFG_RUN);
    n = 0;
    do apb(1'b0, SPWM_OFS_STAT, 32'h0); while (rv[SPWM_ST_FLAG] !== 1'b1 && ++n < 900);
    cmp("restart flag", 32'h1, 32'(rv[SPWM_ST_FLAG]));
    repeat (40) @(posedge clk);
    hiwin(32);
    cmp("zero duty", 32'h0, 32'(h));
    wr(SPWM_OFS_CMPLO, 32'hFF);
    repeat (40) @(posedge clk);
    hiwin(32);
    cmp("over duty", 32'd32, 32'(h));
    wr(SPWM_OFS_CMPLO, 32'h2);
    repeat (40 + $urandom % 16) @(posedge clk);
    slp <= 1'b1;
    hiwin(2);
    hiwin(1);
    p = h;
    hiwin(30);
    cmp("sleep pin", 32'(30 * p), 32'(h));
    apb(1'b0, SPWM_OFS_STAT, 32'h0);
    p = int'(rv[7:0]);
    repeat (20) @(posedge clk);
    rdc("frozen count", SPWM_OFS_STAT, 32'(p) | 32'(rv[11:8]) << 8);
    slp <= 1'b0;
    repeat (40) @(posedge clk);
    hiwin(16);
    cmp("wake duty", 32'd8, 32'(h));
    $display("test sleep done");
    wr(SPWM_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    cmp("release", 32'h0, {29'h0, claim, woe, wout});
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc("cfg0", SPWM_OFS_CFG0, 32'h0);
    rdc("pin", SPWM_OFS_PIN, 32'h1);
    $display("test release done");
    wrap_up;
  end
endmodule

// >>> test/spwm_load.sv
// load on the waveform pin: measures high time and period in clocks
`timescale 1ns/1ps
module spwm_load (
  input  wire logic        clk,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len
);
  logic        lvl;
  logic        lvl_q = 1'b0;
  logic [15:0] hi_c  = 16'h0000;
  logic [15:0] per_c = 16'h0000;
  // released pin is pulled low by the load
  assign lvl = pin_oe & pin_out;
  always_ff @(posedge clk) begin
    lvl_q <= lvl;
    per_c <= (lvl & !lvl_q) ? 16'h0001 : per_c + 16'h0001;
    hi_c  <= (lvl & !lvl_q) ? 16'h0001 : hi_c + {15'h0000, lvl};
    if (lvl & !lvl_q) begin
      per_len <= per_c;
    end
    if (!lvl & lvl_q) begin
      hi_len <= hi_c;
    end
  end
endmodule
